// *** hw/nibble_port_pkg.sv ***
/*
  shared constants for the nibble register port: address map, field
  positions, reset values and update timing.
  assumes a single 200 MHz clock shared by both ends.
*/
package nibble_port_pkg;
  localparam int DATA_W = 16;
  localparam int ADDR_W = 6;
  localparam int NIBBLES_PER_BYTE = 2;
  localparam int BYTES_PER_BANK = 4;
  // register indices
  localparam logic [5:0] NIBBLE_CONTROL_ZERO_ADDR = 6'h00;
  localparam logic [5:0] READ_LATENCY_RANK0_ADDR = 6'h1c;
  localparam logic [5:0] READ_LATENCY_RANK1_ADDR = 6'h1d;
  localparam logic [5:0] READ_LATENCY_RANK2_ADDR = 6'h1e;
  localparam logic [5:0] READ_LATENCY_RANK3_ADDR = 6'h1f;
  // nibble_control_zero fields and reset value
  localparam int TX_DYNAMIC_DELAY_DISABLE_BIT = 10;
  localparam int CTRL0_READ_ONLY_BIT = 9;
  localparam logic [15:0] CTRL0_WRITE_MASK = 16'h0d7f;
  localparam logic [15:0] NIBBLE_CONTROL_ZERO_RESET = 16'h0003;
  localparam logic [15:0] GENERIC_RESET = 16'h0000;
  // update time of a rank delay register: more than two cycles
  localparam int RANK_UPDATE_CYCLES = 4;
  // shadow to cell commit delay for ordinary registers
  localparam int COMMIT_CYCLES = 1;
  // register bus offsets of the controller end (byte addresses)
  localparam logic [7:0] APB_CMD_OFS = 8'h00;
  localparam logic [7:0] APB_WDATA_OFS = 8'h04;
  localparam logic [7:0] APB_RDATA_OFS = 8'h08;
  localparam logic [7:0] APB_STATUS_OFS = 8'h0c;
endpackage

// *** hw/slice_register_port_if.sv ***
/*
  carrier between the fabric caller and the nibble register port.
  assumes both ends run on ref_clk; no clocking block.
*/
`timescale 1ns/1ps
`default_nettype none
interface slice_register_port_if;
  import nibble_port_pkg::*;
  logic reg_write_strobe;
  logic half_byte_select;
  logic [ADDR_W-1:0] reg_address_bus;
  logic [DATA_W-1:0] reg_write_bus;
  logic [DATA_W-1:0] reg_read_bus;
  logic access_ready;

  modport device (
    input reg_write_strobe,
    input half_byte_select,
    input reg_address_bus,
    input reg_write_bus,
    output reg_read_bus,
    output access_ready
  );
  modport caller (
    output reg_write_strobe,
    output half_byte_select,
    output reg_address_bus,
    output reg_write_bus,
    input reg_read_bus,
    input access_ready
  );
endinterface
`default_nettype wire

// *** hw/nibble_register_write_port.sv ***
/*
  device end: the register port of one nibble slice controller. holds a
  small register file, a shadow stage for fabric writes, arbitration
  against the calibration engine and the rank delay update timer.
  timing at the rising edge of ref_clk:
  - plain write: taken at the edge with strobe, select and ready high;
    the cell holds the new value from that edge on.
  - collision: a fabric write meeting a calibration write in one cycle
    drops access_ready at once; the write waits in the shadow stage and
    lands at the first edge with the calibration write gone.
  - rank delay write: access_ready falls in the next cycle and stays low
    for RANK_CYCLES cycles; the value lands as ready returns.
  - read: select high, strobe low; the addressed cell stands on the
    read bus from the next edge until the next read.
  - strobes while busy are ignored; the caller holds its request
    until access_ready is high again.
  - calibration writes always win; they are never delayed.
  - address map: ctrl0 at index 0x00, rank delay registers at
    0x1c..0x1f; one byte carries two such ports, one per nibble, and a
    bank four bytes.
  limitations: cells at or beyond REG_COUNT read as zero and ignore
    writes; only nibble_control_zero has a write mask; the rank timer is
    eight bits wide and RANK_CYCLES below 3 breaks the update rule.
  assumes the caller obeys access_ready; the calibration engine is
    outside and drives a plain write port on the user side; both ends
    share ref_clk and resetn, so no input needs a synchroniser.
*/
// Our own choice: the APB slave port.
// Notes on behaviour
// - calibration collision drops access_ready
// - collided write lands as ready returns
// - caller waits while access_ready is low
// - rank delay writes drop access_ready
// - rank delay update exceeds two cycles
// - no back-to-back rank delay accesses
// - write needs strobe and select high
// - select picks nibble port in byte
// - bank: four bytes, two nibbles each
// - ctrl0 bit 10 disables tx dynamic delay
// - write data valid with strobe cycle
// - only collided and rank delay writes go via shadow
// - read data appears next cycle
`timescale 1ns/1ps
`default_nettype none
module nibble_register_write_port
  import nibble_port_pkg::*;
#(
  parameter int REG_COUNT = 32,
  parameter int RANK_CYCLES = RANK_UPDATE_CYCLES
) (
  input wire logic ref_clk,
  input wire logic resetn,
  slice_register_port_if.device port,
  input wire logic cal_write,
  input wire logic [ADDR_W-1:0] cal_address,
  input wire logic [DATA_W-1:0] cal_data,
  output logic tx_dynamic_delay_disable,
  output logic rank_update_busy
);
  // idle, collided write held, rank update running
  typedef enum logic [2:0] {
    ST_IDLE = 3'b001,
    ST_HOLD = 3'b010,
    ST_RANK = 3'b100
  } port_state_t;

  // all state in one word; cells are the register file
  typedef struct packed {
    port_state_t state;
    logic [ADDR_W-1:0] shadow_addr;
    logic [DATA_W-1:0] shadow_data;
    logic [7:0] timer;
    logic [DATA_W-1:0] read_data;
    logic [REG_COUNT-1:0][DATA_W-1:0] cells;
  } port_regs_t;

  // registered state and its next value
  port_regs_t state_r;
  port_regs_t state_nxt;

  // the four rank delay registers need the long update
  function automatic logic is_rank(input logic [ADDR_W-1:0] a);
    is_rank = (a == READ_LATENCY_RANK0_ADDR) || (a == READ_LATENCY_RANK1_ADDR) ||
              (a == READ_LATENCY_RANK2_ADDR) || (a == READ_LATENCY_RANK3_ADDR);
  endfunction

  // write merge: masked for ctrl0, whole word elsewhere
  function automatic logic [DATA_W-1:0] merge(input logic [ADDR_W-1:0] a,
                                              input logic [DATA_W-1:0] old_v,
                                              input logic [DATA_W-1:0] new_v);
    // ctrl0 keeps reserved and read-only bits out of software's reach
    if (a == NIBBLE_CONTROL_ZERO_ADDR) begin
      merge = (old_v & ~CTRL0_WRITE_MASK) | (new_v & CTRL0_WRITE_MASK);
    end else begin
      merge = new_v;
    end
  endfunction

  // decoded requests and the ready term
  logic fab_write;
  logic fab_read;
  logic ready;

  // write qualified by strobe and select
  assign fab_write = port.reg_write_strobe && port.half_byte_select;
  assign fab_read = !port.reg_write_strobe && port.half_byte_select;
  // ready low unless idle and no collision
  assign ready = (state_r.state == ST_IDLE) && !(fab_write && cal_write);
  // outputs: ready combinational, data from flip-flops
  assign port.access_ready = ready;
  assign port.reg_read_bus = state_r.read_data;
  // bit 10 exported as tx delay mode control
  assign tx_dynamic_delay_disable =
    state_r.cells[NIBBLE_CONTROL_ZERO_ADDR][TX_DYNAMIC_DELAY_DISABLE_BIT];
  assign rank_update_busy = (state_r.state == ST_RANK);

  // next-state: arbitration, shadow commit, read path
  always_comb begin
    state_nxt = state_r;
    // calibration engine always wins the cell write port
    // the engine cannot be stalled, so the fabric side waits
    if (cal_write && int'(cal_address) < REG_COUNT) begin
      state_nxt.cells[cal_address] = merge(cal_address, state_r.cells[cal_address], cal_data);
    end
    // read data registered one cycle later
    if (fab_read && int'(port.reg_address_bus) < REG_COUNT) begin
      state_nxt.read_data = state_r.cells[port.reg_address_bus];
    end else if (fab_read) begin
      // addresses past the file read as zero
      state_nxt.read_data = GENERIC_RESET;
    end
    // port sequencing
    case (state_r.state)
      ST_IDLE: begin
        if (fab_write) begin
          // data sampled with the strobe cycle
          state_nxt.shadow_addr = port.reg_address_bus;
          state_nxt.shadow_data = port.reg_write_bus;
          if (is_rank(port.reg_address_bus)) begin
            // update timer longer than two cycles
            state_nxt.state = ST_RANK;
            state_nxt.timer = 8'(RANK_CYCLES - 1);
          end else if (cal_write) begin
            // collided write waits for a free port
            state_nxt.state = ST_HOLD;
          end else if (int'(port.reg_address_bus) < REG_COUNT) begin
            // plain write lands at this edge
            state_nxt.cells[port.reg_address_bus] =
              merge(port.reg_address_bus, state_r.cells[port.reg_address_bus], port.reg_write_bus);
          end
        end
      end
      ST_HOLD: begin
        // strobes ignored until shadow committed
        // the caller keeps strobing; its repeat is dropped here
        if (!cal_write) begin
          if (int'(state_r.shadow_addr) < REG_COUNT) begin
            state_nxt.cells[state_r.shadow_addr] =
              merge(state_r.shadow_addr, state_r.cells[state_r.shadow_addr], state_r.shadow_data);
          end
          state_nxt.state = ST_IDLE;
        end
      end
      ST_RANK: begin
        // port stays busy until the update ends
        // timer counts down first; commit also waits for a free port
        if (state_r.timer == 8'h00 && !cal_write) begin
          if (int'(state_r.shadow_addr) < REG_COUNT) begin
            state_nxt.cells[state_r.shadow_addr] = state_r.shadow_data;
          end
          state_nxt.state = ST_IDLE;
        end else if (state_r.timer != 8'h00) begin
          state_nxt.timer = state_r.timer - 8'h01;
        end
      end
      default: begin
        // illegal code: back to idle
        state_nxt.state = ST_IDLE;
      end
    endcase
  end

  // register the whole state; reset values are constants
  always_ff @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      state_r.state <= ST_IDLE;
      state_r.shadow_addr <= '0;
      state_r.shadow_data <= '0;
      state_r.timer <= 8'h00;
      state_r.read_data <= '0;
      // every cell resets to a constant
      for (int i = 0; i < REG_COUNT; i++) begin
        state_r.cells[i] <= (i == 0) ? NIBBLE_CONTROL_ZERO_RESET : GENERIC_RESET;
      end
    end else begin
      // one register stage for all state
      state_r <= state_nxt;
    end
  end

  // one port per nibble; a byte instantiates two of these
  // the caller's select picks this one
  // a bank of four bytes thus holds eight ports, each with
  // its own select line from the caller
endmodule
`default_nettype wire

// *** hw/nibble_register_caller.sv ***
/*
  caller end: an APB slave with command registers that turns software
  orders into register port reads and writes, waiting on access_ready.
  assumes one APB master on ref_clk; the port peer shares the clock.
*/
`timescale 1ns/1ps
`default_nettype none
module nibble_register_caller
  import nibble_port_pkg::*;
(
  input wire logic ref_clk,
  input wire logic resetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  slice_register_port_if.caller port
);
  typedef enum logic [2:0] {
    C_IDLE = 3'b001,
    C_ISSUE = 3'b010,
    C_READ = 3'b100
  } caller_state_t;

  typedef struct packed {
    caller_state_t state;
    logic cmd_write;
    logic cmd_sel;
    logic [ADDR_W-1:0] cmd_addr;
    logic [DATA_W-1:0] wdata;
    logic [DATA_W-1:0] rdata;
    logic [31:0] prdata;
  } caller_regs_t;

  caller_regs_t st_r;
  caller_regs_t st_nxt;
  logic apb_wr;
  logic apb_rd;
  logic busy;

  // zero-wait slave: every access completes in its first access cycle
  assign pready = 1'b1;
  assign pslverr = 1'b0;
  assign prdata = st_r.prdata;
  assign apb_wr = psel && penable && pwrite;
  assign apb_rd = psel && !penable && !pwrite;
  assign busy = (st_r.state != C_IDLE);

  // strobe only in the issue cycle
  // data driven in that same cycle
  assign port.reg_write_strobe = (st_r.state == C_ISSUE) && st_r.cmd_write;
  assign port.half_byte_select = (st_r.state == C_ISSUE) && st_r.cmd_sel;
  assign port.reg_address_bus = st_r.cmd_addr;
  assign port.reg_write_bus = st_r.wdata;

  // command sequencing and register decode
  always_comb begin
    st_nxt = st_r;
    // read data prepared in setup so it stands through the access cycle
    if (apb_rd) begin
      case (paddr)
        APB_CMD_OFS: st_nxt.prdata = {24'h000000, st_r.cmd_sel, st_r.cmd_write, st_r.cmd_addr};
        APB_WDATA_OFS: st_nxt.prdata = {16'h0000, st_r.wdata};
        APB_RDATA_OFS: st_nxt.prdata = {16'h0000, st_r.rdata};
        APB_STATUS_OFS: st_nxt.prdata = {30'h00000000, port.access_ready, busy};
        default: st_nxt.prdata = 32'h00000000;
      endcase
    end
    if (apb_wr && paddr == APB_WDATA_OFS && !busy) begin
      st_nxt.wdata = pwdata[15:0];
    end
    case (st_r.state)
      C_IDLE: begin
        // command write starts an access; ignored while busy
        if (apb_wr && paddr == APB_CMD_OFS) begin
          st_nxt.cmd_addr = pwdata[5:0];
          st_nxt.cmd_write = pwdata[6];
          st_nxt.cmd_sel = pwdata[7];
          st_nxt.state = C_ISSUE;
        end
      end
      C_ISSUE: begin
        // keep the request up until ready is high; an unselected one ends after one cycle
        // rank updates keep ready low, so no back-to-back
        if (port.access_ready || !st_r.cmd_sel) begin
          st_nxt.state = (st_r.cmd_write || !st_r.cmd_sel) ? C_IDLE : C_READ;
        end
      end
      C_READ: begin
        // read bus valid one cycle after the request
        st_nxt.rdata = port.reg_read_bus;
        st_nxt.state = C_IDLE;
      end
      default: begin
        st_nxt.state = C_IDLE;
      end
    endcase
  end

  // single register stage for the whole controller
  always_ff @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      st_r <= '{state: C_IDLE, cmd_write: 1'b0, cmd_sel: 1'b0, cmd_addr: '0,
                wdata: '0, rdata: '0, prdata: '0};
    end else begin
      st_r <= st_nxt;
    end
  end
endmodule
`default_nettype wire

// *** verification/nibble_port_asserts.sv ***
/*
  timing checks on the carrier between caller and nibble register port.
  assumes one clock and an async active-low reset shared by both ends.
*/
`timescale 1ns/1ps
`default_nettype none
module nibble_port_asserts
  import nibble_port_pkg::*;
(
  input wire logic ref_clk,
  input wire logic resetn,
  input wire logic reg_write_strobe,
  input wire logic half_byte_select,
  input wire logic [ADDR_W-1:0] reg_address_bus,
  input wire logic [DATA_W-1:0] reg_write_bus,
  input wire logic [DATA_W-1:0] reg_read_bus,
  input wire logic access_ready,
  input wire logic cal_write,
  input wire logic tx_dynamic_delay_disable,
  input wire logic rank_update_busy
);
  default clocking @(posedge ref_clk); endclocking
  default disable iff (!resetn);
  // accepted write, rank delay target, ctrl0 target
  wire take = reg_write_strobe && half_byte_select && access_ready;
  wire rank = reg_address_bus[5:2] == 4'h7;
  wire ctrl = reg_address_bus == NIBBLE_CONTROL_ZERO_ADDR;
  wire hit = reg_write_strobe && half_byte_select && cal_write;

  collide_ready_a: assert property (
    hit |-> !access_ready) else $error("ready high during collision");
  collide_back_a: assert property (
    hit |-> ##[1:20] access_ready) else $error("ready stuck after collision");
  rank_hold_a: assert property (
    take && rank |=> !access_ready [*3]) else $error("rank update too short");
  rank_end_a: assert property (
    take && rank |-> ##[3:10] access_ready) else $error("rank update never ends");
  busy_ready_a: assert property (
    rank_update_busy |-> !access_ready) else $error("ready high while busy");
  ctrl_bit10_a: assert property (
    take && ctrl |=> tx_dynamic_delay_disable == $past(reg_write_bus[TX_DYNAMIC_DELAY_DISABLE_BIT]))
    else $error("tx delay disable not updated");
  read_next_a: assert property (
    half_byte_select && !reg_write_strobe && access_ready && !cal_write && ctrl
    |=> reg_read_bus[10] == tx_dynamic_delay_disable) else $error("read data late or wrong");
  select_gate_a: assert property (
    reg_write_strobe && !half_byte_select && access_ready && !cal_write
    |=> $stable(tx_dynamic_delay_disable)) else $error("write without select");
endmodule
`default_nettype wire

// *** verification/tb_nibble_register_write_port.sv ***
/*
  testbench: APB master on the caller end, calibration writes on the port end.
  assumes pready is answered by the caller; the hang guard ends the run.
*/
`timescale 1ns/1ps
`default_nettype none
module tb_nibble_register_write_port;
  import nibble_port_pkg::*;
  logic ref_clk = 1'b0;
  logic resetn, psel, penable, pwrite, pready, pslverr, cal_write, tx_dis, busy;
  logic [7:0] paddr;
  logic [31:0] pwdata, prdata;
  logic [ADDR_W-1:0] cal_address;
  logic [DATA_W-1:0] cal_data;
  int miscompares = 0;
  int checked = 0;
  int cycles = 0;
  int lows = 0;
  int hits = 0;
  slice_register_port_if i_slice_register_port_if();
  nibble_register_write_port #(.RANK_CYCLES(RANK_UPDATE_CYCLES)) i_nibble_register_write_port (
    .ref_clk(ref_clk), .resetn(resetn), .port(i_slice_register_port_if), .cal_write(cal_write),
    .cal_address(cal_address), .cal_data(cal_data), .tx_dynamic_delay_disable(tx_dis), .rank_update_busy(busy));
  nibble_register_caller i_nibble_register_caller (
    .ref_clk(ref_clk), .resetn(resetn), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
    .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr), .port(i_slice_register_port_if));
  nibble_port_asserts i_nibble_port_asserts (
    .ref_clk(ref_clk), .resetn(resetn), .reg_write_strobe(i_slice_register_port_if.reg_write_strobe),
    .half_byte_select(i_slice_register_port_if.half_byte_select),
    .reg_address_bus(i_slice_register_port_if.reg_address_bus),
    .reg_write_bus(i_slice_register_port_if.reg_write_bus), .reg_read_bus(i_slice_register_port_if.reg_read_bus),
    .access_ready(i_slice_register_port_if.access_ready), .cal_write(cal_write),
    .tx_dynamic_delay_disable(tx_dis), .rank_update_busy(busy));

  always #2.5 ref_clk = ~ref_clk;
  // hang guard, plus counts of ready-low cycles and collisions
  always @(posedge ref_clk) begin
    cycles++;
    if (resetn && !i_slice_register_port_if.access_ready) lows++;
    if (cal_write && i_slice_register_port_if.reg_write_strobe && i_slice_register_port_if.half_byte_select) hits++;
    if (cycles == 20000) begin
      miscompares++;
      final_report();
    end
  end

  task check(input logic [15:0] seen, input logic [15:0] exp, input string msg);
    checked++;
    if (seen !== exp) begin
      miscompares++;
      $display("CHECK FAILED %0t %s seen %h expected %h", $time, msg, seen, exp);
    end
  endtask

  task final_report;
    $display("checked %0d miscompares %0d", checked, miscompares);
    if (miscompares == 0 && checked > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask

  // one apb transfer; waits for pready, data taken at that edge
  task apb(input logic [7:0] a, input logic w, input logic [31:0] d, output logic [31:0] r);
    @(posedge ref_clk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge ref_clk);
    penable <= 1'b1;
    @(posedge ref_clk);
    while (pready !== 1'b1) @(posedge ref_clk);
    r = prdata;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  // one port access: data, command, poll busy, fetch result
  task port_op(input logic [5:0] a, input logic w, input logic s, input logic [15:0] d, output logic [15:0] q);
    logic [31:0] r;
    apb(APB_WDATA_OFS, 1'b1, {16'h0000, d}, r);
    apb(APB_CMD_OFS, 1'b1, {24'h000000, s, w, a}, r);
    r = 32'h1;
    while (r[0] !== 1'b0) apb(APB_STATUS_OFS, 1'b0, 32'h0, r);
    apb(APB_RDATA_OFS, 1'b0, 32'h0, r);
    q = r[15:0];
  endtask

  task t_reset;
    logic [15:0] q;
    port_op(NIBBLE_CONTROL_ZERO_ADDR, 1'b0, 1'b1, 16'h0, q);
    check(q, NIBBLE_CONTROL_ZERO_RESET, "ctrl0 reset");
    check({15'h0, tx_dis}, 16'h0, "tx disable reset");
  endtask

  // all ones then zeros; only writable bits may stick
  task t_ctrl0;
    logic [15:0] q;
    logic [15:0] d;
    for (int i = 0; i < 2; i++) begin
      d = i ? 16'h0000 : 16'hffff;
      port_op(NIBBLE_CONTROL_ZERO_ADDR, 1'b1, 1'b1, d, q);
      port_op(NIBBLE_CONTROL_ZERO_ADDR, 1'b0, 1'b1, 16'h0, q);
      check(q, (d & CTRL0_WRITE_MASK) | (NIBBLE_CONTROL_ZERO_RESET & ~CTRL0_WRITE_MASK), "ctrl0 data");
      check({15'h0, tx_dis}, {15'h0, d[10]}, "tx disable");
    end
  endtask

  task t_select;
    logic [15:0] q;
    port_op(NIBBLE_CONTROL_ZERO_ADDR, 1'b1, 1'b0, 16'h0400, q);
    port_op(NIBBLE_CONTROL_ZERO_ADDR, 1'b0, 1'b1, 16'h0, q);
    check(q, 16'h0000, "unselected write");
  endtask

  // rank registers back to back; each write holds ready low
  task t_rank;
    logic [15:0] q;
    int l0;
    l0 = lows;
    for (int i = 0; i < 4; i++) port_op(READ_LATENCY_RANK0_ADDR + 6'(i), 1'b1, 1'b1, 16'h1230 + 16'(i), q);
    check(16'(lows - l0), 16'(4 * RANK_UPDATE_CYCLES), "ready low cycles");
    for (int i = 0; i < 4; i++) begin
      port_op(READ_LATENCY_RANK0_ADDR + 6'(i), 1'b0, 1'b1, 16'h0, q);
      check(q, 16'h1230 + 16'(i), "rank data");
    end
  endtask

  // calibration writes meanwhile; fabric write must still land
  task t_collide;
    logic [15:0] q;
    cal_address <= 6'h01;
    cal_data <= 16'h5a5a;
    cal_write <= 1'b1;
    fork
      port_op(NIBBLE_CONTROL_ZERO_ADDR, 1'b1, 1'b1, 16'h0410, q);
      begin
        repeat (12) @(posedge ref_clk);
        cal_write <= 1'b0;
      end
    join
    check({15'h0, hits != 0}, 16'h1, "no collision");
    port_op(NIBBLE_CONTROL_ZERO_ADDR, 1'b0, 1'b1, 16'h0, q);
    check(q, 16'h0410, "collided write");
    port_op(6'h01, 1'b0, 1'b1, 16'h0, q);
    check(q, 16'h5a5a, "calibration write");
  endtask

  initial begin
    {resetn, psel, penable, pwrite, cal_write} = 5'h00;
    paddr = 8'h00;
    pwdata = 32'h0;
    cal_address = 6'h00;
    cal_data = 16'h0000;
    repeat (4) @(posedge ref_clk);
    resetn <= 1'b1;
    t_reset();
    t_ctrl0();
    t_select();
    t_rank();
    t_collide();
    final_report();
  end
endmodule
`default_nettype wire
